// [pmcal_host.sv]
/* pmcal_host.sv: host model issuing one decoded command per strobe.
   Assumes the block answers ack or nak one cycle after the strobe. */
`timescale 1ns/10ps
`default_nettype none
module pmcal_host (
  input wire logic mclk,
  input wire logic cmd_ack,
  input wire logic cmd_nak,
  input wire pmcal_pkg::pmcal_word_t cmd_rdata,
  output logic [7:0] cmd_code,
  output logic [0:0] cmd_page,
  output logic cmd_wr,
  output logic cmd_rd,
  output pmcal_pkg::pmcal_word_t cmd_wdata
);
  import pmcal_pkg::*;
  // idle bus at time zero
  initial begin
    cmd_code = 8'h00;
    cmd_page = 1'b0;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // one transfer; data is scrambled after release, while code and page keep their values
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic pg, input pmcal_word_t d, output logic ack,
    output logic nak, output pmcal_word_t rd);
    @(posedge mclk);
    #1;
    cmd_code = code;
    cmd_page = pg;
    cmd_wdata = d;
    cmd_wr = wr;
    cmd_rd = !wr;
    @(posedge mclk);
    #1;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = ~d;
    ack = cmd_ack;
    nak = cmd_nak;
    rd = cmd_rdata;
  endtask
endmodule
`default_nettype wire

// [pmcal_pkg.sv]
/*
 * pmcal_pkg.sv: types shared by the register block.
 * Assumes pmcal_regs.svh for the numeric constants.
 */
`default_nettype none
package pmcal_pkg;
  // startup sequencer: wait for stable straps, then serve commands
  typedef enum logic [0:0] {
    ST_SETTLE,
    ST_RUN
  } pmcal_state_t;
  typedef logic [15:0] pmcal_word_t; // one two-byte register value
endpackage
`default_nettype wire

// [pmcal_regs.svh]
/*
 * pmcal_regs.svh: command codes, field positions, reset values and timing
 * counts of the phase, calibration and overvoltage register block.
 * Assumes nothing of its surroundings; definitions only.
 */
`ifndef PMCAL_REGS_SVH
`define PMCAL_REGS_SVH

// ***********************************************************************
// command codes
// ***********************************************************************
`define PMCAL_CMD_INTERLEAVE 8'h37
`define PMCAL_CMD_GAIN_CAL 8'h38
`define PMCAL_CMD_OFFSET_CAL 8'h39
`define PMCAL_CMD_OV_LIMIT 8'h40

// ***********************************************************************
// field positions
// ***********************************************************************
`define PMCAL_GROUP_MSB 7
`define PMCAL_GROUP_LSB 4
`define PMCAL_POS_MSB 3
`define PMCAL_POS_LSB 0
`define PMCAL_L11_EXP_MSB 15
`define PMCAL_L11_EXP_LSB 11
`define PMCAL_L11_MAN_MSB 10
`define PMCAL_L11_MAN_LSB 0

// ***********************************************************************
// reset values and arithmetic constants
// ***********************************************************************
`define PMCAL_GAIN_RST 16'hb2ae
`define PMCAL_OFFSET_RST 16'hbd00
`define PMCAL_OV_NUM 20'h0_000b
`define PMCAL_OV_DEN 20'h0_000a
`define PMCAL_STEPS_FULL 9'h010
`define PMCAL_STEPS_HALF 5'h08

// ***********************************************************************
// timing: strap must be stable this many cycles before it is taken
// ***********************************************************************
`define PMCAL_SETTLE_NS 40
`define PMCAL_CLK_NS 10
`define PMCAL_SETTLE_CYC ((`PMCAL_SETTLE_NS + `PMCAL_CLK_NS - 1) / `PMCAL_CLK_NS)
// strap synchroniser depth: fewest stable cycles before a strap is trusted
`define PMCAL_SYNC_FILL 8'h03

`endif

// [pmcal_regs_monitor.sv]
/* pmcal_regs_monitor.sv: port assertions for the register block, page 0.
   Assumes it is bound into pmcal_regs_top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
`include "pmcal_regs.svh"
module pmcal_regs_monitor #(
  parameter int NUM_PAGES = 2,
  parameter int SETTLE_CYC = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] cmd_code,
  input wire logic [$clog2(NUM_PAGES)-1:0] cmd_page,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire pmcal_pkg::pmcal_word_t cmd_wdata,
  input wire logic write_protect,
  input wire logic [2:0] share_rank,
  input wire logic cmd_ack,
  input wire logic cmd_nak,
  input wire pmcal_pkg::pmcal_word_t cmd_rdata,
  input wire logic ready,
  input wire logic [NUM_PAGES*5-1:0] phase0_steps,
  input wire logic [NUM_PAGES*5-1:0] phase1_steps,
  input wire logic [NUM_PAGES*5-1:0] gain_exp,
  input wire logic [NUM_PAGES*11-1:0] gain_man,
  input wire logic [NUM_PAGES*16-1:0] ov_limit
);
  import pmcal_pkg::*;
  // ***********************************************************************
  // helpers
  // ***********************************************************************
  wire logic req = cmd_wr | cmd_rd; // any strobe
  wire logic known = cmd_code inside {`PMCAL_CMD_INTERLEAVE,
    `PMCAL_CMD_GAIN_CAL, `PMCAL_CMD_OFFSET_CAL, `PMCAL_CMD_OV_LIMIT};
  // a write that must land on page 0; rd with wr is left out here, though the block takes it as a write
  wire logic wr_ok = cmd_wr & ~cmd_rd & ready & ~write_protect
    & (cmd_page == '0);
  wire logic [4:0] p0 = phase0_steps[4:0]; // first phase, page 0
  wire logic [4:0] p1_exp = (p0 > 5'h08) ? p0 - 5'h08 : p0 + 5'h08;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ***********************************************************************
  // assertions
  // ***********************************************************************
  a_answer_once: assert property (req |=> cmd_ack ^ cmd_nak)
    else $error("strobe not answered by exactly one of ack and nak");
  a_idle_quiet: assert property (!req |=> !cmd_ack && !cmd_nak)
    else $error("answer without a strobe");
  a_protect_nak: assert property (cmd_wr && write_protect |=> cmd_nak)
    else $error("protected write not refused");
  a_unknown_nak: assert property (req && !known |=> cmd_nak)
    else $error("unknown command not refused");
  a_upper_zero: assert property (cmd_rd && !cmd_wr && ready &&
    cmd_code == `PMCAL_CMD_INTERLEAVE |=> cmd_ack && cmd_rdata[15:8] == 8'h00)
    else $error("interleave upper byte not zero");
  a_phase_half: assert property ((p0 != 5'h00) && $stable(p0) |->
    phase1_steps[4:0] == p1_exp)
    else $error("second phase not half a turn after first");
  a_full_circle: assert property (wr_ok && share_rank == 3'h0 &&
    cmd_code == `PMCAL_CMD_INTERLEAVE && cmd_wdata[7:0] == 8'h00
    |-> ##2 p0 == 5'h10)
    else $error("zero group and position not sixteen steps");
  a_gain_fields: assert property (wr_ok &&
    cmd_code == `PMCAL_CMD_GAIN_CAL |=>
    {gain_exp[4:0], gain_man[10:0]} == $past(cmd_wdata))
    else $error("gain exponent or mantissa field wrong");
  a_ov_store: assert property (wr_ok &&
    cmd_code == `PMCAL_CMD_OV_LIMIT |=> ov_limit[15:0] == $past(cmd_wdata))
    else $error("overvoltage limit not stored");
  a_ready_holds: assert property (ready |=> ready)
    else $error("ready dropped without reset");
  // main scenarios reached
  c_write: cover property (wr_ok ##1 cmd_ack);
  c_read: cover property (cmd_rd && !cmd_wr ##1 cmd_ack);
  c_protect: cover property (cmd_wr && write_protect ##1 cmd_nak);
endmodule
bind pmcal_regs_top pmcal_regs_monitor #(.NUM_PAGES(NUM_PAGES),
  .SETTLE_CYC(SETTLE_CYC)) i_mon (
  .mclk(mclk), .resetn(resetn), .cmd_code(cmd_code), .cmd_page(cmd_page),
  .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
  .write_protect(write_protect), .share_rank(share_rank),
  .cmd_ack(cmd_ack), .cmd_nak(cmd_nak), .cmd_rdata(cmd_rdata),
  .ready(ready), .phase0_steps(phase0_steps), .phase1_steps(phase1_steps),
  .gain_exp(gain_exp), .gain_man(gain_man), .ov_limit(ov_limit));
`default_nettype wire

// [pmcal_regs_top.sv]
/*
 * pmcal_regs_top.sv: paged command registers for phase interleave,
 * current-sense calibration and overvoltage limit, with phase offsets.
 * Assumes a command decoder outside that hands over one decoded command
 * per cmd_wr or cmd_rd pulse, and strap pins that settle after power-on.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pmcal_regs.svh"

// What this block does
// - group size bits 7:4, zero means sixteen
// - position bits 3:0, zero means sixteen
// - offset steps round(pos*16/size), 22.5 each
// - offset above 360 wraps down by as many 360s as it takes to fit one turn
// - second phase sits 180 after first
// - share-group phases spread automatically
// - interleave paged, writable, protectable, strap default
// - gain Linear-11 milliohm, resets b2ae
// - offset Linear-11 ampere, resets bd00
// - ov limit paged, protectable, Linear-16 unsigned
// - ov limit starts at 1.10 times strap
module pmcal_regs_top #(
  parameter int NUM_PAGES = 2,
  parameter int SETTLE_CYC = `PMCAL_SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] cmd_code,
  input wire logic [$clog2(NUM_PAGES)-1:0] cmd_page,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire pmcal_pkg::pmcal_word_t cmd_wdata,
  input wire logic write_protect,
  input wire logic [7:0] cfg_interleave_strap,
  input wire logic [15:0] output_voltage_strap,
  input wire logic [2:0] share_size,
  input wire logic [2:0] share_rank,
  output logic cmd_ack,
  output logic cmd_nak,
  output pmcal_pkg::pmcal_word_t cmd_rdata,
  output logic ready,
  output logic [NUM_PAGES*5-1:0] phase0_steps,
  output logic [NUM_PAGES*5-1:0] phase1_steps,
  output logic [NUM_PAGES*5-1:0] gain_exp,
  output logic [NUM_PAGES*11-1:0] gain_man,
  output logic [NUM_PAGES*5-1:0] offset_exp,
  output logic [NUM_PAGES*11-1:0] offset_man,
  output logic [NUM_PAGES*16-1:0] ov_limit
);
  import pmcal_pkg::*;

  // ***********************************************************************
  // strap synchronisers
  // ***********************************************************************
  logic [7:0] ilv_s1_q, ilv_s2_q, ilv_s3_q; // interleave strap stages
  logic [15:0] output_voltage_strap_s1_q, output_voltage_strap_s2_q, output_voltage_strap_s3_q; // voltage strap stages

  // three stages; only the last two are compared
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ilv_s1_q <= 8'h00;
      ilv_s2_q <= 8'h00;
      ilv_s3_q <= 8'h00;
      output_voltage_strap_s1_q <= 16'h0000;
      output_voltage_strap_s2_q <= 16'h0000;
      output_voltage_strap_s3_q <= 16'h0000;
    end else begin
      ilv_s1_q <= cfg_interleave_strap;
      ilv_s2_q <= ilv_s1_q;
      ilv_s3_q <= ilv_s2_q;
      output_voltage_strap_s1_q <= output_voltage_strap;
      output_voltage_strap_s2_q <= output_voltage_strap_s1_q;
      output_voltage_strap_s3_q <= output_voltage_strap_s2_q;
    end
  end

  wire strap_stable = (ilv_s2_q == ilv_s3_q) && (output_voltage_strap_s2_q == output_voltage_strap_s3_q);

  // ***********************************************************************
  // power-on defaults from straps
  // ***********************************************************************
  wire [19:0] ov_prod = {4'h0, output_voltage_strap_s3_q} * `PMCAL_OV_NUM;
  wire [19:0] ov_quot = ov_prod / `PMCAL_OV_DEN;
  // saturate: a strap near full scale must not wrap to a tiny limit
  wire [15:0] ov_default = (ov_quot[19:16] != 4'h0) ? 16'hffff :
                           ov_quot[15:0];

  pmcal_state_t state_q, state_d;
  logic [7:0] settle_q, settle_d; // cycles the straps have been stable
  // all stages reset to zero and so look stable before the pin value
  // reaches the last one; never load before the chain has filled
  wire [7:0] settle_min = 8'(SETTLE_CYC);
  wire [7:0] settle_need = (settle_min > `PMCAL_SYNC_FILL) ? settle_min :
                           `PMCAL_SYNC_FILL;

  // count stable cycles; any change restarts the wait
  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    unique case (state_q)
      ST_SETTLE: begin
        if (!strap_stable) begin
          settle_d = 8'h00;
        end else if (settle_q >= settle_need) begin
          state_d = ST_RUN;
        end else begin
          settle_d = settle_q + 8'h01;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_SETTLE;
      settle_q <= 8'h00;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
    end
  end

  wire load_defaults = (state_q == ST_SETTLE) && (state_d == ST_RUN);
  assign ready = (state_q == ST_RUN);

  // ***********************************************************************
  // command decode
  // ***********************************************************************
  wire hit_ilv = (cmd_code == `PMCAL_CMD_INTERLEAVE);
  wire hit_gain = (cmd_code == `PMCAL_CMD_GAIN_CAL);
  wire hit_off = (cmd_code == `PMCAL_CMD_OFFSET_CAL);
  wire hit_ov = (cmd_code == `PMCAL_CMD_OV_LIMIT);
  wire hit_any = hit_ilv | hit_gain | hit_off | hit_ov;
  wire page_ok = (int'(cmd_page) < NUM_PAGES);
  // every register here is protectable; refused writes leave it untouched
  wire wr_ok = cmd_wr && ready && hit_any && page_ok
               && !write_protect;
  wire rd_ok = cmd_rd && !cmd_wr && ready && hit_any && page_ok;

  // ***********************************************************************
  // paged register storage
  // ***********************************************************************
  logic [7:0] ilv_q [NUM_PAGES]; // upper byte not stored
  pmcal_word_t gain_q [NUM_PAGES];
  pmcal_word_t off_q [NUM_PAGES];
  pmcal_word_t ov_q [NUM_PAGES];

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAGES; gp++) begin : g_page
      wire sel = wr_ok && (int'(cmd_page) == gp);
      logic [4:0] grp, pos; // decoded 1..16
      logic [8:0] raw, base, spread, rot, wrapped0;
      logic [4:0] p0, p1sum;

      // interleave: strap at startup, then host writes low byte
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          ilv_q[gp] <= 8'h00;
        end else if (load_defaults) begin
          ilv_q[gp] <= ilv_s3_q;
        end else if (sel && hit_ilv) begin
          ilv_q[gp] <= cmd_wdata[7:0];
        end
      end

      // calibration and limit words
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          gain_q[gp] <= `PMCAL_GAIN_RST;
          off_q[gp] <= `PMCAL_OFFSET_RST;
          ov_q[gp] <= 16'h0000;
        end else begin
          if (load_defaults) begin
            ov_q[gp] <= ov_default;
          end else if (sel && hit_ov) begin
            ov_q[gp] <= cmd_wdata;
          end
          if (sel && hit_gain) begin
            gain_q[gp] <= cmd_wdata;
          end
          if (sel && hit_off) begin
            off_q[gp] <= cmd_wdata;
          end
        end
      end

      // zero in either field stands for sixteen
      assign grp = (ilv_q[gp][`PMCAL_GROUP_MSB:`PMCAL_GROUP_LSB] == 4'h0) ?
                   5'h10 : {1'b0, ilv_q[gp][7:4]};
      assign pos = (ilv_q[gp][`PMCAL_POS_MSB:`PMCAL_POS_LSB] == 4'h0) ?
                   5'h10 : {1'b0, ilv_q[gp][3:0]};
      // round half up: (pos*32 + grp) / (2*grp)
      // ten bits: position sixteen times 32 needs the tenth bit
      assign raw = 9'(({5'h00, pos} * 10'h020 + {5'h00, grp})
                      / ({5'h00, grp} * 10'h002));
      // phases of one share group spread by the block itself; the
      // same interleave word in every member keeps them aligned
      assign spread = 9'(({6'h00, share_rank} * 9'h010
                         + {6'h00, share_size})
                         / ((share_size == 3'h0) ? 9'h002 :
                            {6'h00, share_size} * 9'h002));
      assign base = raw + spread;
      // above a full turn folds back; exactly 360 is kept as 16 steps
      assign rot = (base > `PMCAL_STEPS_FULL) ?
                   ((base - 9'h001) & 9'h00f) + 9'h001 : base;
      assign wrapped0 = rot;
      assign p0 = wrapped0[4:0];
      assign p1sum = p0 + `PMCAL_STEPS_HALF;

      // outputs registered to keep the data ports glitch free
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          phase0_steps[gp*5 +: 5] <= 5'h00;
          phase1_steps[gp*5 +: 5] <= 5'h00;
        end else begin
          phase0_steps[gp*5 +: 5] <= p0;
          phase1_steps[gp*5 +: 5] <= (p1sum > 5'h10) ?
                                     p1sum - 5'h10 : p1sum;
        end
      end

      // linear-11 split of the calibration words
      assign gain_exp[gp*5 +: 5] =
        gain_q[gp][`PMCAL_L11_EXP_MSB:`PMCAL_L11_EXP_LSB];
      assign gain_man[gp*11 +: 11] =
        gain_q[gp][`PMCAL_L11_MAN_MSB:`PMCAL_L11_MAN_LSB];
      assign offset_exp[gp*5 +: 5] =
        off_q[gp][`PMCAL_L11_EXP_MSB:`PMCAL_L11_EXP_LSB];
      assign offset_man[gp*11 +: 11] =
        off_q[gp][`PMCAL_L11_MAN_MSB:`PMCAL_L11_MAN_LSB];
      assign ov_limit[gp*16 +: 16] = ov_q[gp];
    end
  endgenerate

  // ***********************************************************************
  // read mux and answer
  // ***********************************************************************
  wire [$clog2(NUM_PAGES)-1:0] pg = page_ok ? cmd_page : '0;
  wire [15:0] rd_mux = hit_ilv ? {8'h00, ilv_q[pg]} :
                       hit_gain ? gain_q[pg] :
                       hit_off ? off_q[pg] :
                       hit_ov ? ov_q[pg] : 16'h0000;

  // one answer per request, the cycle after it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      cmd_ack <= wr_ok | rd_ok;
      cmd_nak <= (cmd_wr | cmd_rd) & ~(wr_ok | rd_ok);
      if (rd_ok) begin
        cmd_rdata <= rd_mux;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_pmcal_regs_top.sv]
/* tb_pmcal_regs_top.sv: self-checking bench for the register block.
   Assumes pmcal_host as the command source and the bound monitor. */
`timescale 1ns/10ps
`default_nettype none
`include "pmcal_regs.svh"
module tb_pmcal_regs_top;
  import pmcal_pkg::*;
  logic mclk, resetn, cmd_wr, cmd_rd, write_protect, cmd_ack, cmd_nak, ready;
  logic [7:0] cmd_code, cfg_interleave_strap;
  logic [0:0] cmd_page;
  pmcal_word_t cmd_wdata, cmd_rdata;
  logic [15:0] output_voltage_strap;
  logic [2:0] share_size, share_rank;
  logic [9:0] phase0_steps, phase1_steps, gain_exp, offset_exp;
  logic [21:0] gain_man, offset_man;
  logic [31:0] ov_limit;
  int errors, n_checks;
  // short settle keeps the run brief
  pmcal_regs_top #(.NUM_PAGES(2), .SETTLE_CYC(1)) i_dut (
    .mclk(mclk), .resetn(resetn), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
    .write_protect(write_protect),
    .cfg_interleave_strap(cfg_interleave_strap),
    .output_voltage_strap(output_voltage_strap),
    .share_size(share_size), .share_rank(share_rank),
    .cmd_ack(cmd_ack), .cmd_nak(cmd_nak), .cmd_rdata(cmd_rdata),
    .ready(ready), .phase0_steps(phase0_steps),
    .phase1_steps(phase1_steps), .gain_exp(gain_exp), .gain_man(gain_man),
    .offset_exp(offset_exp), .offset_man(offset_man), .ov_limit(ov_limit)
  );
  pmcal_host i_host (
    .mclk(mclk), .cmd_ack(cmd_ack), .cmd_nak(cmd_nak), .cmd_rdata(cmd_rdata),
    .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one command; d is the expected value on a read
  task automatic access(input logic wr, input logic [7:0] code,
    input logic pg, input pmcal_word_t d, input logic ok);
    logic a, n;
    pmcal_word_t r;
    i_host.xfer(wr, code, pg, d, a, n, r);
    check({15'h0000, a}, {15'h0000, ok});
    check({15'h0000, n}, {15'h0000, !ok});
    if (!wr && ok) check(r, d);
  endtask
  // expected offset in steps, wrapped into 1..16
  function automatic logic [4:0] steps(input logic [7:0] il, input int add);
    int n, p, s;
    n = (il[7:4] == 4'h0) ? 16 : int'(il[7:4]);
    p = (il[3:0] == 4'h0) ? 16 : int'(il[3:0]);
    s = (p * 32 + n) / (2 * n) + add;
    return 5'((s - 1) % 16 + 1);
  endfunction
  task automatic t_defaults();
    for (int pg = 0; pg < 2; pg++) begin
      access(0, `PMCAL_CMD_GAIN_CAL, pg[0], 16'hb2ae, 1);
      access(0, `PMCAL_CMD_OFFSET_CAL, pg[0], 16'hbd00, 1);
      access(0, `PMCAL_CMD_INTERLEAVE, pg[0], 16'h0035, 1);
      access(0, `PMCAL_CMD_OV_LIMIT, pg[0], 16'h1199, 1);
    end
    check(ov_limit[31:16], 16'h1199);
    $display("test defaults done");
  endtask
  task automatic t_interleave();
    logic [7:0] tbl [4] = '{8'h00, 8'h32, 8'h21, 8'h5f};
    foreach (tbl[i]) begin
      // same setting on every page, as for a share group
      access(1, `PMCAL_CMD_INTERLEAVE, 1'b0, {8'hff, tbl[i]}, 1);
      access(1, `PMCAL_CMD_INTERLEAVE, 1'b1, {8'hff, tbl[i]}, 1);
      @(posedge mclk);
      #1;
      check(phase0_steps[4:0], steps(tbl[i], 0));
      check(phase1_steps[4:0], steps(tbl[i], 8));
      check(phase0_steps[9:5], steps(tbl[i], 0));
      access(0, `PMCAL_CMD_INTERLEAVE, 1'b1, {8'h00, tbl[i]}, 1);
    end
    $display("test interleave done");
  endtask
  task automatic t_protect();
    write_protect = 1'b1;
    access(1, `PMCAL_CMD_OV_LIMIT, 1'b0, 16'h0abc, 0);
    access(1, `PMCAL_CMD_INTERLEAVE, 1'b0, 16'h0011, 0);
    write_protect = 1'b0;
    access(0, `PMCAL_CMD_OV_LIMIT, 1'b0, 16'h1199, 1);
    access(1, 8'h41, 1'b0, 16'h0000, 0);
    access(0, 8'h36, 1'b1, 16'h0000, 0);
    $display("test protect done");
  endtask
  // rank 1 of a two-member share group: spread round(1*16/4) = 4 steps
  task automatic t_share();
    share_size = 3'h2;
    share_rank = 3'h1;
    @(posedge mclk);
    #1;
    check(phase0_steps[4:0], steps(8'h5f, 4));
    check(phase1_steps[9:5], steps(8'h5f, 12));
    share_size = 3'h1;
    share_rank = 3'h0;
    @(posedge mclk);
    #1;
    check(phase0_steps[9:5], steps(8'h5f, 0));
    $display("test share done");
  endtask
  task automatic t_linear();
    access(1, `PMCAL_CMD_GAIN_CAL, 1'b1, 16'h87ff, 1);
    check(gain_exp[9:5], 5'h10);
    check(gain_man[21:11], 11'h7ff);
    check({gain_exp[4:0], gain_man[10:0]}, 16'hb2ae);
    access(1, `PMCAL_CMD_OFFSET_CAL, 1'b0, 16'h0400, 1);
    check(offset_exp[4:0], 5'h00);
    check(offset_man[10:0], 11'h400);
    access(1, `PMCAL_CMD_OV_LIMIT, 1'b1, 16'hffff, 1);
    check(ov_limit[31:16], 16'hffff);
    $display("test linear done");
  endtask
  initial begin
    resetn = 1'b0;
    write_protect = 1'b0;
    cfg_interleave_strap = 8'h35;
    output_voltage_strap = 16'h1000;
    share_size = 3'h1;
    share_rank = 3'h0;
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    access(1, `PMCAL_CMD_GAIN_CAL, 1'b0, 16'h1234, 0);
    for (int i = 0; i < 50 && ready !== 1'b1; i++) @(posedge mclk);
    #1;
    if (ready !== 1'b1) begin
      errors++;
    end else begin
      t_defaults();
      t_interleave();
      t_protect();
      t_share();
      t_linear();
    end
    stop_test();
  end
endmodule
`default_nettype wire
